// >>> hdl/led_effect_timing_config.sv
/*
 * led effect timing configuration registers and per-channel effect selection.
 * assumes the serial front end presents byte accesses on the register port
 * and that the four fade intervals come from global logic on mclk.
 */
// Function
// - high hold select picks fade interval one when 0, two when 1.
// - low dwell select at bit 0 picks fade interval one or two.
// - two-bit rise field maps codes 0..3 to fade intervals one..four.
// - high brightness code gives target intensity, 100 percent falling with code.
// - power-on register fields: rise 7:6, brightness 5:3, repeat 2:0, all read/write.
// - power-on registers 12h,14h,16h,18h govern channel groups 0, 1-3, 4-6, 7-9.
// - repeat field codes 0..4 give 0,1,2,4,6 repeats.
`timescale 1ns/10ps
module led_effect_timing_config
	import led_effect_pkg::*;
#(
	parameter int CHANNELS = NUM_CHANNELS
) (
	input  wire logic                    mclk,
	input  wire logic                    rstn,
	input  wire logic                    ce,
	input  wire logic [7:0]              reg_addr,
	input  wire logic                    reg_wr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_rd,
	output logic      [7:0]              reg_rdata_q,
	input  wire fade_set_t               fade_set,
	output chan_effect_t [CHANNELS-1:0]  effect_q
);

	// grouping of channels is wired for ten outputs only
	if (CHANNELS != NUM_CHANNELS) begin : gen_bad_channels
		$error("channel grouping is fixed at ten channels");
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0] pwr_q   [NUM_GROUPS];
	logic [7:0] touch_q [NUM_GROUPS];
	logic [NUM_GROUPS-1:0] pwr_hit;
	logic [NUM_GROUPS-1:0] touch_hit;
	logic [7:0] rd_mux;

	// power-on group registers sit at even offsets 12h..18h
	assign pwr_hit[0] = (reg_addr == POWER_ON_EFFECT_GROUP0_OFS);
	assign pwr_hit[1] = (reg_addr == POWER_ON_EFFECT_GROUP1_OFS);
	assign pwr_hit[2] = (reg_addr == POWER_ON_EFFECT_GROUP2_OFS);
	assign pwr_hit[3] = (reg_addr == POWER_ON_EFFECT_GROUP3_OFS);
	assign touch_hit[0] = (reg_addr == TOUCH_EFFECT_GROUP0_OFS);
	assign touch_hit[1] = (reg_addr == TOUCH_EFFECT_GROUP1_OFS);
	assign touch_hit[2] = (reg_addr == TOUCH_EFFECT_GROUP2_OFS);
	assign touch_hit[3] = (reg_addr == TOUCH_EFFECT_GROUP3_OFS);

	// unmapped offsets read as zero and ignore writes
	assign rd_mux = pwr_hit[0] ? pwr_q[0] : pwr_hit[1] ? pwr_q[1] :
			pwr_hit[2] ? pwr_q[2] : pwr_hit[3] ? pwr_q[3] :
			touch_hit[0] ? touch_q[0] : touch_hit[1] ? touch_q[1] :
			touch_hit[2] ? touch_q[2] : touch_hit[3] ? touch_q[3] : 8'h00;

	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : gen_grp
			always_ff @(posedge mclk) begin
				if (!rstn) begin
					pwr_q[g]   <= CFG_RESET;
					touch_q[g] <= CFG_RESET;
				end else if (ce && reg_wr) begin
					if (pwr_hit[g]) begin
						pwr_q[g] <= reg_wdata;
					end
					if (touch_hit[g]) begin
						touch_q[g] <= reg_wdata;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			reg_rdata_q <= 8'h00;
		end else if (ce && reg_rd) begin
			reg_rdata_q <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// per-channel effect selection
	// ------------------------------------------------------------
	// a registered stage keeps outputs glitch free; changes land one cycle later
	genvar c;
	generate
		for (c = 0; c < CHANNELS; c++) begin : gen_ch
			localparam logic [1:0] GRP = group_of(c);
			wire logic [1:0] rise_sel = pwr_q[GRP][RISE_LSB +: 2];
			wire logic [2:0] bright   = pwr_q[GRP][HIGH_BRIGHT_LSB +: 3];
			wire logic [2:0] rep      = pwr_q[GRP][REPEAT_LSB +: 3];
			wire logic       hh_sel   = touch_q[GRP][HIGH_HOLD_BIT];
			wire logic       ld_sel   = touch_q[GRP][LOW_DWELL_BIT];
			chan_effect_t    eff_d;

			// only selection happens here; durations are global
			assign eff_d.rise_time = (rise_sel == 2'h0) ? fade_set.one :
						 (rise_sel == 2'h1) ? fade_set.two :
						 (rise_sel == 2'h2) ? fade_set.three :
						 fade_set.four;
			assign eff_d.high_hold_time = hh_sel ? fade_set.two : fade_set.one;
			assign eff_d.low_dwell_time = ld_sel ? fade_set.two : fade_set.one;
			assign eff_d.high_percent   = high_percent_of(bright);
			assign eff_d.repeat_count   = repeat_of(rep);

			always_ff @(posedge mclk) begin
				if (!rstn) begin
					effect_q[c] <= '0;
				end else if (ce) begin
					effect_q[c] <= eff_d;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	AST_WRITE_READBACK: assert property (
		ce && reg_wr && reg_addr == POWER_ON_EFFECT_GROUP2_OFS ##1
		ce && !reg_wr && reg_rd && reg_addr == POWER_ON_EFFECT_GROUP2_OFS
		|=> reg_rdata_q == $past(reg_wdata, 2))
		else $error("power-on register readback mismatch");
	AST_UNMAPPED_ZERO: assert property (
		ce && reg_rd && reg_addr == 8'h13 |=> reg_rdata_q == 8'h00)
		else $error("unmapped offset did not read zero");
	AST_GROUP1_SHARED: assert property (
		effect_q[1] == effect_q[2] && effect_q[2] == effect_q[3])
		else $error("channels 1 to 3 differ");
	AST_GROUP3_SHARED: assert property (
		effect_q[7] == effect_q[8] && effect_q[8] == effect_q[9])
		else $error("channels 7 to 9 differ");
	AST_RISE_FOUR: assert property (
		ce && pwr_q[0][7:6] == 2'h3 |=> effect_q[0].rise_time == $past(fade_set.four))
		else $error("rise code 3 did not pick interval four");
	AST_HIGH_HOLD: assert property (
		ce && touch_q[2][1] |=> effect_q[5].high_hold_time == $past(fade_set.two))
		else $error("high hold select 1 did not pick interval two");
	AST_LOW_DWELL: assert property (
		ce && !touch_q[3][0] |=> effect_q[8].low_dwell_time == $past(fade_set.one))
		else $error("low dwell select 0 did not pick interval one");
	AST_BRIGHT_65: assert property (
		ce && pwr_q[1][5:3] == 3'h3 |=> effect_q[2].high_percent == 7'h41)
		else $error("brightness code 3 not 65 percent");
	AST_REPEAT_SIX: assert property (
		ce && pwr_q[2][2:0] == 3'h4 |=> effect_q[4].repeat_count == 3'h6)
		else $error("repeat code 4 not six repeats");
	AST_FREEZE: assert property (
		!ce |=> $stable(effect_q) && $stable(reg_rdata_q))
		else $error("state moved while clock enable low");

	// register port: writes land, read data stands until the next taken read
	AST_WRITE_LANDS: assert property (
		ce && reg_wr && pwr_hit[3] |=> pwr_q[3] == $past(reg_wdata))
		else $error("power-on write did not land");
	AST_TOUCH_LANDS: assert property (
		ce && reg_wr && touch_hit[0] |=> touch_q[0] == $past(reg_wdata))
		else $error("touch effect write did not land");
	AST_RDATA_HOLDS: assert property (
		!(ce && reg_rd) |=> $stable(reg_rdata_q))
		else $error("read data moved without a read");

	// fade interval selection for the remaining codes
	AST_RISE_ONE: assert property (
		ce && pwr_q[1][7:6] == 2'h0 |=> effect_q[3].rise_time == $past(fade_set.one))
		else $error("rise code 0 did not pick interval one");
	AST_RISE_TWO: assert property (
		ce && pwr_q[2][7:6] == 2'h1 |=> effect_q[6].rise_time == $past(fade_set.two))
		else $error("rise code 1 did not pick interval two");
	AST_RISE_THREE: assert property (
		ce && pwr_q[3][7:6] == 2'h2 |=> effect_q[7].rise_time == $past(fade_set.three))
		else $error("rise code 2 did not pick interval three");
	AST_HIGH_HOLD_ONE: assert property (
		ce && !touch_q[0][1] |=> effect_q[0].high_hold_time == $past(fade_set.one))
		else $error("high hold select 0 did not pick interval one");
	AST_LOW_DWELL_TWO: assert property (
		ce && touch_q[1][0] |=> effect_q[1].low_dwell_time == $past(fade_set.two))
		else $error("low dwell select 1 did not pick interval two");

	// intensity decoding
	AST_BRIGHT_100: assert property (
		ce && pwr_q[0][5:3] == 3'h0 |=> effect_q[0].high_percent == 7'h64)
		else $error("brightness code 0 not 100 percent");
	AST_BRIGHT_90: assert property (
		ce && pwr_q[2][5:3] == 3'h1 |=> effect_q[6].high_percent == 7'h5a)
		else $error("brightness code 1 not 90 percent");
	AST_BRIGHT_80: assert property (
		ce && pwr_q[3][5:3] == 3'h2 |=> effect_q[9].high_percent == 7'h50)
		else $error("brightness code 2 not 80 percent");

	// repeat decoding
	AST_REPEAT_ZERO: assert property (
		ce && pwr_q[0][2:0] == 3'h0 |=> effect_q[0].repeat_count == 3'h0)
		else $error("repeat code 0 not zero repeats");
	AST_REPEAT_ONE: assert property (
		ce && pwr_q[1][2:0] == 3'h1 |=> effect_q[1].repeat_count == 3'h1)
		else $error("repeat code 1 not one repeat");
	AST_REPEAT_TWO: assert property (
		ce && pwr_q[3][2:0] == 3'h2 |=> effect_q[8].repeat_count == 3'h2)
		else $error("repeat code 2 not two repeats");
	AST_REPEAT_FOUR: assert property (
		ce && pwr_q[0][2:0] == 3'h3 |=> effect_q[0].repeat_count == 3'h4)
		else $error("repeat code 3 not four repeats");

	// ------------------------------------------------------------
	// cover points
	// ------------------------------------------------------------
	COV_WRITE_GROUP0: cover property (ce && reg_wr && pwr_hit[0]);
	COV_READ_TOUCH:   cover property (ce && reg_rd && touch_hit[3]);
	COV_RISE_THREE:   cover property (effect_q[9].rise_time == fade_set.three);
	COV_WRITE_READ:   cover property (ce && reg_wr && pwr_hit[2] ##1 ce && reg_rd && pwr_hit[2]);
	COV_FROZEN_WRITE: cover property (!ce && reg_wr && pwr_hit[1]);

endmodule

// >>> common/led_effect_pkg.sv
/*
 * shared constants and carrier types for the led effect timing registers.
 * assumes one system clock and a byte-wide register access port.
 */
package led_effect_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] TOUCH_EFFECT_GROUP0_OFS = 8'h07;
	localparam logic [7:0] TOUCH_EFFECT_GROUP1_OFS = 8'h09;
	localparam logic [7:0] TOUCH_EFFECT_GROUP2_OFS = 8'h0b;
	localparam logic [7:0] TOUCH_EFFECT_GROUP3_OFS = 8'h0d;
	localparam logic [7:0] POWER_ON_EFFECT_GROUP0_OFS = 8'h12;
	localparam logic [7:0] POWER_ON_EFFECT_GROUP1_OFS = 8'h14;
	localparam logic [7:0] POWER_ON_EFFECT_GROUP2_OFS = 8'h16;
	localparam logic [7:0] POWER_ON_EFFECT_GROUP3_OFS = 8'h18;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int RISE_LSB       = 6;
	localparam int HIGH_BRIGHT_LSB = 3;
	localparam int REPEAT_LSB     = 0;
	localparam int HIGH_HOLD_BIT  = 1;
	localparam int LOW_DWELL_BIT  = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// ------------------------------------------------------------
	// counts
	// ------------------------------------------------------------
	localparam int NUM_GROUPS   = 4;
	localparam int NUM_CHANNELS = 10;
	localparam int TIME_W       = 16;

	typedef struct packed {
		logic [TIME_W-1:0] rise_time;
		logic [TIME_W-1:0] high_hold_time;
		logic [TIME_W-1:0] low_dwell_time;
		logic [6:0]        high_percent;
		logic [2:0]        repeat_count;
	} chan_effect_t;

	typedef struct packed {
		logic [TIME_W-1:0] one;
		logic [TIME_W-1:0] two;
		logic [TIME_W-1:0] three;
		logic [TIME_W-1:0] four;
	} fade_set_t;

	function automatic logic [6:0] high_percent_of(input logic [2:0] code);
		case (code)
			3'h0: high_percent_of = 7'h64;
			3'h1: high_percent_of = 7'h5a;
			3'h2: high_percent_of = 7'h50;
			3'h3: high_percent_of = 7'h41;
			3'h4: high_percent_of = 7'h32;
			3'h5: high_percent_of = 7'h28;
			3'h6: high_percent_of = 7'h14;
			default: high_percent_of = 7'h00;
		endcase
	endfunction

	function automatic logic [2:0] repeat_of(input logic [2:0] code);
		case (code)
			3'h0: repeat_of = 3'h0;
			3'h1: repeat_of = 3'h1;
			3'h2: repeat_of = 3'h2;
			3'h3: repeat_of = 3'h4;
			default: repeat_of = 3'h6;
		endcase
	endfunction

	function automatic logic [1:0] group_of(input int ch);
		if (ch == 0) begin
			group_of = 2'h0;
		end else if (ch <= 3) begin
			group_of = 2'h1;
		end else if (ch <= 6) begin
			group_of = 2'h2;
		end else begin
			group_of = 2'h3;
		end
	endfunction

endpackage

// >>> dv/host_model.sv
/*
 * host side model: drives byte writes and reads on the register port.
 * assumes mclk is the design clock and reads answer one edge later.
 */
`timescale 1ns/10ps
module host_model (
	input  wire logic       mclk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata_q
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// ------------------------------------------------------------
	// bus cycles
	// ------------------------------------------------------------
	// released data lines show the inverse so a stale value never passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata_q;
	endtask

	// write and read back on the very next edge, the tightest legal order
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		reg_rd = 1'b0;
		q = reg_rdata_q;
	endtask
endmodule

// >>> dv/testbench.sv
/*
 * self-checking bench for the led effect timing registers.
 * assumes host_model stands in for the serial front end.
 */
`timescale 1ns/10ps
module testbench import led_effect_pkg::*; ;
	logic                     mclk = 1'b0;
	logic                     rstn = 1'b0;
	logic                     ce = 1'b1;
	logic [7:0]               reg_addr, reg_wdata, reg_rdata_q, v;
	logic                     reg_wr, reg_rd;
	fade_set_t                fade_set = {16'h1111, 16'h2222, 16'h3333, 16'h4444};
	chan_effect_t [9:0]       effect_q;
	int                       mismatches = 0;
	int                       checks = 0;
	int                       pct[8] = '{100, 90, 80, 65, 50, 40, 20, 0};
	int                       rep[8] = '{0, 1, 2, 4, 6, 6, 6, 6};

	always #5 mclk = ~mclk;

	host_model u_host_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
	led_effect_timing_config u_led_effect_timing_config (.mclk(mclk), .rstn(rstn), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q), .fade_set(fade_set), .effect_q(effect_q));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host_model.rd(a, d);
		chk("read data", {8'h00, e}, {8'h00, d});
	endtask

	function automatic logic [15:0] pick(input logic [1:0] s);
		pick = (s == 2'h0) ? fade_set.one : (s == 2'h1) ? fade_set.two :
			(s == 2'h2) ? fade_set.three : fade_set.four;
	endfunction

	// group of a channel worked out independently: 0 | 1-3 | 4-6 | 7-9
	function automatic int grp(input int c);
		grp = (c == 0) ? 0 : (c + 2) / 3;
	endfunction

	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		for (int g = 0; g < 4; g++) begin
			rd_chk(POWER_ON_EFFECT_GROUP0_OFS + 8'(2 * g), 8'h00);
		end
		chk("reset percent", 16'd100, 16'(effect_q[5].high_percent));
		$display("test reset done");
	endtask

	task automatic test_power_on();
		for (int k = 0; k < 8; k++) begin
			for (int g = 0; g < 4; g++) begin
				v = {2'((k + g) % 4), 3'((k + g) % 8), 3'((k + g) % 5)};
				u_host_model.wr(POWER_ON_EFFECT_GROUP0_OFS + 8'(2 * g), v);
			end
			settle();
			for (int c = 0; c < 10; c++) begin
				v = {2'((k + grp(c)) % 4), 3'((k + grp(c)) % 8), 3'((k + grp(c)) % 5)};
				chk("rise", pick(v[7:6]), effect_q[c].rise_time);
				chk("percent", 16'(pct[v[5:3]]), 16'(effect_q[c].high_percent));
				chk("repeat", 16'(rep[v[2:0]]), 16'(effect_q[c].repeat_count));
			end
			rd_chk(POWER_ON_EFFECT_GROUP3_OFS, v);
		end
		$display("test power on done");
	endtask

	task automatic test_touch();
		for (int k = 0; k < 8; k++) begin
			fade_set.two = 16'h2222 + 16'(k);
			for (int g = 0; g < 4; g++) begin
				u_host_model.wr(TOUCH_EFFECT_GROUP0_OFS + 8'(2 * g), {6'h2a, 2'((k + g) % 4)});
			end
			settle();
			for (int c = 0; c < 10; c++) begin
				v = 8'((k + grp(c)) % 4);
				chk("hold", pick({1'b0, v[1]}), effect_q[c].high_hold_time);
				chk("dwell", pick({1'b0, v[0]}), effect_q[c].low_dwell_time);
			end
		end
		$display("test touch done");
	endtask

	task automatic test_refused();
		u_host_model.wr(8'h13, 8'h5a);
		rd_chk(8'h13, 8'h00);
		u_host_model.wr(POWER_ON_EFFECT_GROUP1_OFS, 8'ha5);
		ce = 1'b0;
		u_host_model.wr(POWER_ON_EFFECT_GROUP1_OFS, 8'h3c);
		ce = 1'b1;
		rd_chk(POWER_ON_EFFECT_GROUP1_OFS, 8'ha5);
		$display("test refused done");
	endtask

	task automatic test_back_to_back();
		logic [7:0] d;
		u_host_model.wr_rd(POWER_ON_EFFECT_GROUP2_OFS, 8'h9c, d);
		chk("write then read", 16'h009c, {8'h00, d});
		u_host_model.wr_rd(TOUCH_EFFECT_GROUP1_OFS, 8'hd6, d);
		chk("touch readback", 16'h00d6, {8'h00, d});
		settle();
		chk("percent", 16'd65, 16'(effect_q[4].high_percent));
		chk("hold", fade_set.two, effect_q[2].high_hold_time);
		chk("dwell", fade_set.one, effect_q[3].low_dwell_time);
		$display("test back to back done");
	endtask

	task automatic test_mid_reset();
		u_host_model.wr(POWER_ON_EFFECT_GROUP3_OFS, 8'hff);
		settle();
		chk("percent", 16'h0000, 16'(effect_q[9].high_percent));
		rstn = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("rise in reset", 16'h0000, effect_q[9].rise_time);
		rstn = 1'b1;
		rd_chk(POWER_ON_EFFECT_GROUP3_OFS, 8'h00);
		chk("percent after reset", 16'd100, 16'(effect_q[9].high_percent));
		chk("rise after reset", fade_set.one, effect_q[7].rise_time);
		$display("test mid reset done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#500000;
		mismatches++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge mclk);
		#1;
		rstn = 1'b1;
		test_reset();
		test_power_on();
		test_touch();
		test_refused();
		test_back_to_back();
		test_mid_reset();
		wrap_up();
	end
endmodule
